/* File: scan_port_map.vh */
// Constants of the boundary-scan test port
`ifndef SCAN_PORT_MAP_VH
`define SCAN_PORT_MAP_VH

// ------------------------------------------------------------
// Register lengths
// ------------------------------------------------------------
`define IR_LEN          10
`define SIG_LEN         32
`define SIG_USER_LEN    7
`define SIG_FIXED_LEN   25
`define CHAIN_LEN       1104
`define CHAIN_LEN_MIN   480
`define CHAIN_LEN_MAX   1440

// ------------------------------------------------------------
// Instruction codes
// ------------------------------------------------------------
`define OP_EXTEST       10'h000
`define OP_SAMPLE       10'h055
`define OP_IDCODE       10'h006
`define OP_USERCODE     10'h007
`define OP_CFG_LOAD     10'h002
`define OP_CFG_START    10'h003
`define OP_BYPASS       10'h3FF

// ------------------------------------------------------------
// Reset values and fixed fields
// ------------------------------------------------------------
`define IR_CAPTURE      10'h001
`define SIG_FIXED_VAL   25'h0000001
`define ID_VALUE        32'h12345001

// ------------------------------------------------------------
// Controller state codes
// ------------------------------------------------------------
`define ST_RESET        4'hF
`define ST_IDLE         4'hC
`define ST_SEL_DR       4'h7
`define ST_CAP_DR       4'h6
`define ST_SHIFT_DR     4'h2
`define ST_EXIT1_DR     4'h1
`define ST_PAUSE_DR     4'h3
`define ST_EXIT2_DR     4'h0
`define ST_UPD_DR       4'h5
`define ST_SEL_IR       4'h4
`define ST_CAP_IR       4'hE
`define ST_SHIFT_IR     4'hA
`define ST_EXIT1_IR     4'h9
`define ST_PAUSE_IR     4'hB
`define ST_EXIT2_IR     4'h8
`define ST_UPD_IR       4'hD

`endif

/* File: scan_chain.v */
// Boundary cell chain: capture, shift and update stages
`timescale 1ns/1ps
`default_nettype none

module scan_chain #(
	parameter LEN = 1104
) (
	// Clock and control
	input  wire           clk,
	input  wire           rst_n,
	input  wire           en,
	input  wire           capture,
	input  wire           shift,
	input  wire           update,
	// Data
	input  wire           si,
	input  wire [LEN-1:0] pins_in,
	output wire           so,
	output reg  [LEN-1:0] upd_q
);

	reg [LEN-1:0] shift_q;

	assign so = shift_q[0];

	// ------------------------------------------------------------
	// Shift stage and update stage
	// ------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= {LEN{1'b0}};
			upd_q   <= {LEN{1'b0}};
		end else if (en) begin
			if (capture)
				shift_q <= pins_in;
			else if (shift)
				shift_q <= {si, shift_q[LEN-1:1]};
			if (update)
				upd_q <= shift_q;
		end
	end

endmodule // scan_chain

`default_nettype wire

/* File: scan_test_port.v */
// Boundary-scan test access port with instruction and data registers
//
// Operation
// - Instruction register is ten bits, shifted in from serial input.
// - User signature is 32 bits: 7 user bits, 25 fixed bits.
// - Bypass puts one flop between serial input and output.
// - Sample/preload captures pins and keeps a pattern for later drive.
// - External test drives chain pattern out and captures input pins.
// - User signature instruction shifts the signature out serially.
// - Identification instruction shifts the identification value out.
// - Chain length parameter, 480 to 1440, default 1104 cells.
// - Configuration instructions let the controller load configuration.
`timescale 1ns/1ps
`default_nettype none
`include "scan_port_map.vh"

module scan_test_port #(
	parameter CHAIN_LEN = `CHAIN_LEN,
	parameter [31:0] ID_VALUE = `ID_VALUE
) (
	// System
	input  wire                 CLOCK,
	input  wire                 RST_N,
	input  wire                 CLK_EN,
	// Test pins
	input  wire                 TCK,
	input  wire                 TMS,
	input  wire                 TDI,
	output reg                  TDO,
	output reg                  TDO_OE,
	// Boundary pins
	input  wire [CHAIN_LEN-1:0] PIN_IN,
	input  wire [CHAIN_LEN-1:0] CORE_OUT,
	output wire [CHAIN_LEN-1:0] PIN_OUT,
	// User signature and configuration
	input  wire [6:0]           USER_SIG,
	output reg                  CFG_BIT,
	output reg                  CFG_BIT_VALID,
	output reg                  CFG_START
);

	reg  [2:0]           tck_q;
	reg  [1:0]           tms_q;
	reg  [1:0]           tdi_q;
	reg  [3:0]           state_q;
	reg  [3:0]           state_d;
	reg  [9:0]           ir_sh_q;
	reg  [9:0]           ir_q;
	reg  [31:0]          dr32_q;
	reg                  byp_q;
	reg                  extest_q;
	wire                 tck_rise;
	wire                 tck_fall;
	wire                 tms_s;
	wire                 tdi_s;
	wire                 cap_dr;
	wire                 sh_dr;
	wire                 upd_dr;
	wire                 bnd_sel;
	wire                 bnd_so;
	wire [CHAIN_LEN-1:0] bnd_upd;
	reg                  dr_bit;

	// ------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			tck_q <= 3'h0;
			tms_q <= 2'h3;
			tdi_q <= 2'h3;
		end else if (CLK_EN) begin
			tck_q <= {tck_q[1:0], TCK};
			tms_q <= {tms_q[0], TMS};
			tdi_q <= {tdi_q[0], TDI};
		end
	end
	assign tck_rise = tck_q[1] & ~tck_q[2];
	assign tck_fall = ~tck_q[1] & tck_q[2];
	assign tms_s    = tms_q[1];
	assign tdi_s    = tdi_q[1];

	// ------------------------------------------------------------
	// Controller next state
	// ------------------------------------------------------------
	// Sixteen-state sequence
	always @* begin
		state_d = state_q;
		case (state_q)
			`ST_RESET:    state_d = tms_s ? `ST_RESET : `ST_IDLE;
			`ST_IDLE:     state_d = tms_s ? `ST_SEL_DR : `ST_IDLE;
			`ST_SEL_DR:   state_d = tms_s ? `ST_SEL_IR : `ST_CAP_DR;
			`ST_CAP_DR:   state_d = tms_s ? `ST_EXIT1_DR : `ST_SHIFT_DR;
			`ST_SHIFT_DR: state_d = tms_s ? `ST_EXIT1_DR : `ST_SHIFT_DR;
			`ST_EXIT1_DR: state_d = tms_s ? `ST_UPD_DR : `ST_PAUSE_DR;
			`ST_PAUSE_DR: state_d = tms_s ? `ST_EXIT2_DR : `ST_PAUSE_DR;
			`ST_EXIT2_DR: state_d = tms_s ? `ST_UPD_DR : `ST_SHIFT_DR;
			`ST_UPD_DR:   state_d = tms_s ? `ST_SEL_DR : `ST_IDLE;
			`ST_SEL_IR:   state_d = tms_s ? `ST_RESET : `ST_CAP_IR;
			`ST_CAP_IR:   state_d = tms_s ? `ST_EXIT1_IR : `ST_SHIFT_IR;
			`ST_SHIFT_IR: state_d = tms_s ? `ST_EXIT1_IR : `ST_SHIFT_IR;
			`ST_EXIT1_IR: state_d = tms_s ? `ST_UPD_IR : `ST_PAUSE_IR;
			`ST_PAUSE_IR: state_d = tms_s ? `ST_EXIT2_IR : `ST_PAUSE_IR;
			`ST_EXIT2_IR: state_d = tms_s ? `ST_UPD_IR : `ST_SHIFT_IR;
			`ST_UPD_IR:   state_d = tms_s ? `ST_SEL_DR : `ST_IDLE;
			default:      state_d = `ST_RESET;
		endcase
	end

	assign cap_dr  = tck_rise & (state_q == `ST_CAP_DR);
	assign sh_dr   = tck_rise & (state_q == `ST_SHIFT_DR);
	assign upd_dr  = tck_rise & (state_q == `ST_UPD_DR);
	// Sample/preload and external test use the chain
	assign bnd_sel = (ir_q == `OP_SAMPLE) | (ir_q == `OP_EXTEST);

	// ------------------------------------------------------------
	// Controller, instruction and data registers
	// ------------------------------------------------------------
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state_q       <= `ST_RESET;
			ir_sh_q       <= `IR_CAPTURE;
			ir_q          <= `OP_IDCODE;
			dr32_q        <= 32'h00000000;
			byp_q         <= 1'b0;
			extest_q      <= 1'b0;
			CFG_BIT       <= 1'b0;
			CFG_BIT_VALID <= 1'b0;
			CFG_START     <= 1'b0;
		end else if (CLK_EN) begin
			CFG_BIT_VALID <= 1'b0;
			CFG_START     <= 1'b0;
			if (tck_rise) begin
				state_q <= state_d;
				if (state_d == `ST_RESET) begin
					ir_q     <= `OP_IDCODE;
					extest_q <= 1'b0;
				end
				case (state_q)
					`ST_CAP_IR:   ir_sh_q <= `IR_CAPTURE;
					`ST_SHIFT_IR: ir_sh_q <= {tdi_s, ir_sh_q[9:1]};
					`ST_UPD_IR: begin
						ir_q     <= ir_sh_q;
						extest_q <= (ir_sh_q == `OP_EXTEST);
					end
					`ST_CAP_DR: begin
						byp_q <= 1'b0;
						if (ir_q == `OP_IDCODE)
							dr32_q <= ID_VALUE;
						else if (ir_q == `OP_USERCODE)
							dr32_q <= {`SIG_FIXED_VAL, USER_SIG};
					end
					`ST_SHIFT_DR: begin
						byp_q  <= tdi_s;
						dr32_q <= {tdi_s, dr32_q[31:1]};
						if (ir_q == `OP_CFG_LOAD) begin
							CFG_BIT       <= tdi_s;
							CFG_BIT_VALID <= 1'b1;
						end
					end
					`ST_UPD_DR: begin
						if (ir_q == `OP_CFG_START)
							CFG_START <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Boundary chain
	// ------------------------------------------------------------
	// Chain sized by parameter
	scan_chain #(
		.LEN     (CHAIN_LEN)
	) u_chain (
		.clk     (CLOCK),
		.rst_n   (RST_N),
		.en      (CLK_EN),
		.capture (cap_dr & bnd_sel),
		.shift   (sh_dr & bnd_sel),
		.update  (upd_dr & bnd_sel),
		.si      (tdi_s),
		.pins_in (PIN_IN),
		.so      (bnd_so),
		.upd_q   (bnd_upd)
	);

	assign PIN_OUT = extest_q ? bnd_upd : CORE_OUT;

	// ------------------------------------------------------------
	// Serial output on falling test clock
	// ------------------------------------------------------------
	always @* begin
		if (bnd_sel)
			dr_bit = bnd_so;
		else if ((ir_q == `OP_IDCODE) | (ir_q == `OP_USERCODE))
			dr_bit = dr32_q[0];
		else
			dr_bit = byp_q;
	end

	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			TDO    <= 1'b0;
			TDO_OE <= 1'b0;
		end else if (CLK_EN & tck_fall) begin
			TDO    <= (state_q == `ST_SHIFT_IR) ? ir_sh_q[0] : dr_bit;
			TDO_OE <= (state_q == `ST_SHIFT_IR) |
			          (state_q == `ST_SHIFT_DR);
		end
	end

endmodule // scan_test_port

`default_nettype wire

/* File: scan_test_port_monitor.sv */
// Assertion checker for the scan test port
`timescale 1ns/1ps
`default_nettype none
module scan_test_port_monitor #(
	parameter CHAIN_LEN = 8
) (
	// System
	input wire                 CLOCK,
	input wire                 RST_N,
	// Test pins
	input wire                 TCK,
	input wire                 TMS,
	input wire                 TDO,
	input wire                 TDO_OE,
	// Boundary and configuration
	input wire [CHAIN_LEN-1:0] CORE_OUT,
	input wire [CHAIN_LEN-1:0] PIN_OUT,
	input wire                 CFG_BIT_VALID,
	input wire                 CFG_START
);
// ----------------------------------------
// Cycles since each test clock edge, and rising edges in a row with TMS high
// ----------------------------------------
reg       tck_q;
reg [3:0] fcnt_q;
reg [3:0] rcnt_q;
reg [2:0] ones_q;
always @(posedge CLOCK or negedge RST_N) begin
	if (!RST_N) begin
		tck_q  <= 1'b0;
		fcnt_q <= 4'hF;
		rcnt_q <= 4'hF;
		ones_q <= 3'h0;
	end else begin
		tck_q  <= TCK;
		fcnt_q <= (tck_q && !TCK) ? 4'h0 : fcnt_q + {3'h0, fcnt_q != 4'hF};
		rcnt_q <= (!tck_q && TCK) ? 4'h0 : rcnt_q + {3'h0, rcnt_q != 4'hF};
		if (!tck_q && TCK)
			ones_q <= TMS ? ones_q + {2'h0, ones_q != 3'h5} : 3'h0;
	end
end
// ----------------------------------------
// Properties
// ----------------------------------------
default clocking @(posedge CLOCK); endclocking
default disable iff (!RST_N);
sequence reset_seen;
	$rose(ones_q == 3'h5);
endsequence
sequence pins_quiet;
	(PIN_OUT == CORE_OUT && !TDO_OE)[*3];
endsequence
a_tdo_after_fall: assert property ($changed(TDO) |-> fcnt_q <= 4'h5)
	else $error("serial output moved away from a falling test clock");
a_valid_on_rise: assert property (CFG_BIT_VALID |-> rcnt_q <= 4'h5)
	else $error("config bit strobe not tied to a rising test clock");
a_start_on_rise: assert property (CFG_START |-> rcnt_q <= 4'h5)
	else $error("config start not tied to a rising test clock");
a_valid_single: assert property (CFG_BIT_VALID |=> !CFG_BIT_VALID)
	else $error("config bit strobe longer than one cycle");
a_start_single: assert property (CFG_START |=> !CFG_START)
	else $error("config start longer than one cycle");
a_cfg_apart: assert property (CFG_START |-> !CFG_BIT_VALID)
	else $error("config start and bit strobe together");
a_tap_reset_pins: assert property (reset_seen |-> ##6 pins_quiet)
	else $error("pins or output enable wrong in test logic reset");
a_tap_reset_cfg: assert property (reset_seen |-> ##6 (!CFG_START)[*3])
	else $error("config start in test logic reset");
endmodule // scan_test_port_monitor
bind scan_test_port scan_test_port_monitor #(.CHAIN_LEN(CHAIN_LEN))
	scan_test_port_monitor_inst (.CLOCK(CLOCK), .RST_N(RST_N), .TCK(TCK),
	.TMS(TMS), .TDO(TDO), .TDO_OE(TDO_OE), .CORE_OUT(CORE_OUT),
	.PIN_OUT(PIN_OUT), .CFG_BIT_VALID(CFG_BIT_VALID), .CFG_START(CFG_START));
`default_nettype wire

/* File: scan_controller.sv */
// Model of the external scan controller
`timescale 1ns/1ps
`default_nettype none
module scan_controller (
	// System
	input  wire logic CLOCK,
	// Test pins
	output var  logic TCK,
	output var  logic TMS,
	output var  logic TDI,
	input  wire logic TDO
);
initial begin
	TCK = 1'b0;
	TMS = 1'b1;
	TDI = 1'b0;
end
// one test clock, low outside frames
task step(input logic ms, input logic di, output logic dout);
	TMS = ms;
	TDI = di;
	repeat (4) @(negedge CLOCK);
	dout = TDO;
	TCK = 1'b1;
	repeat (4) @(negedge CLOCK);
	TCK = 1'b0;
endtask
task walk(input logic [4:0] ms, input int n);
	logic d;
	for (int i = 0; i < n; i++)
		step(ms[i], 1'b0, d);
endtask
task shift(input int n, input logic [31:0] din, output logic [31:0] dout);
	dout = 32'h0;
	for (int i = 0; i < n; i++)
		step(i == n - 1, din[i], dout[i]);
endtask
task ir(input logic [9:0] code, output logic [31:0] cap);
	walk(5'h03, 4);
	shift(10, {22'h0, code}, cap);
	walk(5'h01, 2);
endtask
task dr(input int n, input logic [31:0] din, output logic [31:0] dout);
	walk(5'h01, 3);
	shift(n, din, dout);
	walk(5'h01, 2);
endtask
endmodule // scan_controller
`default_nettype wire

/* File: scan_test_port_test.sv */
// Testbench of the scan test port
`timescale 1ns/1ps
`default_nettype none
`include "scan_port_map.vh"
module scan_test_port_test;
localparam [31:0] ID = 32'h0ABC0001; // arbitrary value
logic        CLOCK    = 1'b0;
logic        RST_N    = 1'b0;
logic [7:0]  PIN_IN   = 8'hA5;
logic [7:0]  CORE_OUT = 8'h3C;
logic [6:0]  USER_SIG = 7'h5A;
wire         TCK, TMS, TDI, TDO, TDO_OE, CFG_BIT, CFG_BIT_VALID, CFG_START;
// Released serial line shows the inverse of the last bit
wire         TDO_LINE = TDO_OE ? TDO : ~TDO;
wire  [7:0]  PIN_OUT;
logic [31:0] got, cfg_q = 32'h0;
int          miscompares = 0, cmp_count = 0, cyc = 0, nvalid = 0, nstart = 0;
scan_test_port #(.CHAIN_LEN(8), .ID_VALUE(ID)) scan_test_port_inst (
	.CLOCK(CLOCK), .RST_N(RST_N), .CLK_EN(1'b1), .TCK(TCK), .TMS(TMS),
	.TDI(TDI), .TDO(TDO), .TDO_OE(TDO_OE), .PIN_IN(PIN_IN),
	.CORE_OUT(CORE_OUT), .PIN_OUT(PIN_OUT), .USER_SIG(USER_SIG),
	.CFG_BIT(CFG_BIT), .CFG_BIT_VALID(CFG_BIT_VALID), .CFG_START(CFG_START));
scan_controller scan_controller_inst (.CLOCK(CLOCK), .TCK(TCK), .TMS(TMS),
	.TDI(TDI), .TDO(TDO_LINE));
initial forever #5 CLOCK = ~CLOCK;
always @(posedge CLOCK) begin
	cyc++;
	if (CFG_BIT_VALID === 1'b1) begin
		nvalid++;
		cfg_q = {CFG_BIT, cfg_q[31:1]};
	end
	if (CFG_START === 1'b1)
		nstart++;
	if (cyc == 20000) begin
		miscompares++;
		print_verdict;
	end
end
task check(input string what, input logic [31:0] exp, input logic [31:0] act);
	cmp_count++;
	if (exp !== act) begin
		miscompares++;
		$display("wrong value %s expected %h seen %h", what, exp, act);
	end
endtask
task print_verdict;
	$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
	if (miscompares == 0 && cmp_count > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
endtask
task test_idcode;
	scan_controller_inst.walk(5'h1F, 5);
	scan_controller_inst.walk(5'h00, 1);
	scan_controller_inst.dr(32, 32'h0, got);
	check("idcode", ID, got);
	$display("test idcode done");
endtask
task test_usercode;
	scan_controller_inst.ir(`OP_USERCODE, got);
	check("ir capture", {22'h0, `IR_CAPTURE}, got);
	scan_controller_inst.dr(32, 32'h0, got);
	check("usercode", {`SIG_FIXED_VAL, USER_SIG}, got);
	$display("test usercode done");
endtask
task test_bypass;
	logic [9:0] codes [2];
	codes = '{`OP_BYPASS, 10'h2AA};
	for (int i = 0; i < 2; i++) begin
		scan_controller_inst.ir(codes[i], got);
		scan_controller_inst.dr(8, 32'hB6, got);
		check("bypass", 32'h6C, got);
	end
	$display("test bypass done");
endtask
task test_boundary;
	scan_controller_inst.ir(`OP_SAMPLE, got);
	scan_controller_inst.dr(8, 32'h96, got);
	check("sample capture", 32'hA5, got);
	check("sample pins", {24'h0, CORE_OUT}, {24'h0, PIN_OUT});
	PIN_IN = 8'h4B;
	scan_controller_inst.ir(`OP_EXTEST, got);
	check("preload drive", 32'h96, {24'h0, PIN_OUT});
	scan_controller_inst.dr(16, 32'hC3E1, got);
	check("extest capture", 32'hE14B, got);
	check("extest drive", 32'hC3, {24'h0, PIN_OUT});
	$display("test boundary done");
endtask
task test_tap_reset;
	scan_controller_inst.ir(`OP_EXTEST, got);
	check("extest held", 32'hC3, {24'h0, PIN_OUT});
	scan_controller_inst.walk(5'h07, 3);
	check("reset pins", {24'h0, CORE_OUT}, {24'h0, PIN_OUT});
	scan_controller_inst.walk(5'h00, 1);
	scan_controller_inst.dr(32, 32'h0, got);
	check("reset idcode", ID, got);
	$display("test tap reset done");
endtask
task test_config;
	nvalid = 0;
	scan_controller_inst.ir(`OP_CFG_LOAD, got);
	scan_controller_inst.dr(12, 32'hABC, got);
	check("config bits", 32'd12, nvalid);
	check("config data", 32'hABC, {20'h0, cfg_q[31:20]});
	nstart = 0;
	scan_controller_inst.ir(`OP_CFG_START, got);
	scan_controller_inst.dr(1, 32'h0, got);
	check("config start", 32'd1, nstart);
	$display("test config done");
endtask
initial begin
	repeat (4) @(negedge CLOCK);
	RST_N = 1'b1;
	repeat (3) @(negedge CLOCK);
	test_idcode;
	test_usercode;
	test_bypass;
	test_boundary;
	test_tap_reset;
	test_config;
	print_verdict;
end
endmodule // scan_test_port_test
`default_nettype wire
